/* File: rtl/error_queue_pkg.sv */
// error queue package: error codes, class ranges, status bit positions
// assumes a single clock domain and signed 16-bit error codes
package error_queue_pkg;
  localparam int              CODE_W         = 16;
  localparam int              DEPTH_DEFAULT  = 8;
  localparam logic [15:0]     CODE_NONE      = 16'h0000;
  localparam logic [15:0]     CODE_OVERFLOW  = 16'hFEA2; // -350
  localparam logic [15:0]     CODE_GET       = 16'hFF97; // -105
  localparam logic [15:0]     CODE_SUFFIX    = 16'hFF8E; // -114
  localparam logic [15:0]     CODE_NUMERIC   = 16'hFF88; // -120
  localparam logic [15:0]     CODE_EXPONENT  = 16'hFF85; // -123
  localparam logic [15:0]     CODE_STRING    = 16'hFF69; // -151
  localparam logic [15:0]     CODE_PROTECTED = 16'hFF35; // -203
  localparam logic [15:0]     CODE_PARAM     = 16'hFF24; // -220
  localparam logic [15:0]     CODE_CONFLICT  = 16'hFF23; // -221
  localparam logic [15:0]     CODE_HW_ERROR  = 16'hFF10; // -240
  localparam logic [15:0]     CODE_HW_MISS   = 16'hFF0F; // -241
  localparam logic [15:0]     CODE_PROG_NAME = 16'hFEE6; // -282
  localparam logic [15:0]     CODE_PROG_RUN  = 16'hFEE4; // -284
  localparam logic [15:0]     CODE_PROG_SYN  = 16'hFEE3; // -285
  localparam logic [15:0]     CODE_MEM_USE   = 16'hFEDE; // -290
  localparam int              CMD_LO         = -199;
  localparam int              CMD_HI         = -100;
  localparam int              EXE_LO         = -299;
  localparam int              EXE_HI         = -200;
  localparam int              DEV_LO         = -399;
  localparam int              DEV_HI         = -300;
  localparam int              QRY_LO         = -499;
  localparam int              QRY_HI         = -400;
  localparam int              DEV_POS_LO     = 1;
  localparam int              EXP_LIMIT      = 32000;
  localparam int              BIT_QUERY      = 2;
  localparam int              BIT_DEVICE     = 3;
  localparam int              BIT_EXEC       = 4;
  localparam int              BIT_CMD        = 5;
  localparam int              EVENT_W        = 8;
  localparam int              NUM_SRC        = 14;
  localparam logic [NUM_SRC*16-1:0] SRC_CODES = {
    CODE_MEM_USE, CODE_PROG_SYN, CODE_PARAM, CODE_PROG_RUN, CODE_PROG_NAME,
    CODE_HW_MISS, CODE_HW_ERROR, CODE_CONFLICT, CODE_PROTECTED, CODE_STRING,
    CODE_NUMERIC, CODE_EXPONENT, CODE_SUFFIX, CODE_GET};
endpackage : error_queue_pkg

/* File: rtl/error_class_decode.sv */
// error class decoder: maps a signed error code to event status bits
// assumes codes are two's complement, CODE_W wide
`timescale 1ns/1ps
module error_class_decode
  import error_queue_pkg::*;
(
  input  wire logic [CODE_W-1:0]  code,
  input  wire logic               valid,
  output logic      [EVENT_W-1:0] class_bits
);
  int value;
  always_comb begin
    value      = int'($signed(code));
    class_bits = '0;
    if (valid) begin
      class_bits[BIT_CMD]    = (value >= CMD_LO) && (value <= CMD_HI); // R5
      class_bits[BIT_EXEC]   = (value >= EXE_LO) && (value <= EXE_HI); // R6
      class_bits[BIT_DEVICE] = ((value >= DEV_LO) && (value <= DEV_HI)) || (value >= DEV_POS_LO); // R17
      class_bits[BIT_QUERY]  = (value >= QRY_LO) && (value <= QRY_HI); // R18
    end
  end
endmodule : error_class_decode

/* File: rtl/error_queue_status_reporter.sv */
// error queue with class reporting toward the event status register
// assumes sources pulse once per detected error, host pulses query and clear
//
// What this block does
// (R1) queue error codes, read back in order
// (R2) full queue: newest entry becomes overflow code
// (R3) empty queue answers zero
// (R4) clear-status or reading last entry empties queue
// (R5) codes -199..-100 set event bit 5
// (R6) codes -299..-200 set event bit 4
// (R7) execution checks only after rounding, evaluation; only R11-R13 sources wait for eval_done
// (R8) queue trigger-in-message and suffix-range codes
// (R9) queue exponent code when exponent exceeds 32000
// (R10) queue numeric-data and invalid-string codes
// (R11) queue command-protected code for disabled commands
// (R12) queue setting-conflict code for conflicting state
// (R13) queue hardware-error and hardware-missing codes
// (R14) queue illegal-program-name code
// (R15) queue program-running code while program runs
// (R16) queue parameter, program-syntax, memory-use codes
// (R17) device-specific codes set event bit 3
// (R18) codes -499..-400 set event bit 2
// (R19) queue depth is a parameter
`timescale 1ns/1ps
module error_queue_status_reporter
  import error_queue_pkg::*;
#(
  parameter int DEPTH = DEPTH_DEFAULT // R19
)(
  input  wire logic                 mclk,
  input  wire logic                 resetn,
  input  wire logic                 trigger_in_message,
  input  wire logic                 suffix_out_of_range,
  input  wire logic                 numeric_malformed,
  input  wire logic                 exponent_valid,
  input  wire logic [31:0]          exponent_value,
  input  wire logic                 string_invalid,
  input  wire logic                 eval_done,
  input  wire logic                 command_disabled,
  input  wire logic                 setting_conflict,
  input  wire logic                 hardware_fault,
  input  wire logic                 hardware_missing,
  input  wire logic                 program_name_bad,
  input  wire logic                 program_running_op,
  input  wire logic                 program_data_bad,
  input  wire logic                 program_syntax_bad,
  input  wire logic                 memory_use_bad,
  input  wire logic                 other_error,
  input  wire logic [CODE_W-1:0]    other_code,
  input  wire logic                 error_query,
  input  wire logic                 clear_status,
  output logic                      answer_valid,
  output logic      [CODE_W-1:0]    answer_code,
  output logic      [EVENT_W-1:0]   event_set,
  output logic      [$clog2(DEPTH+1)-1:0] queue_count
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  if (DEPTH < 2) begin : g_depth_check
    $error("depth must be at least 2");
  end

  typedef struct packed {
    logic [DEPTH-1:0][CODE_W-1:0] mem;
    logic [PW-1:0]                rd_ptr;
    logic [PW-1:0]                wr_ptr;
    logic [CW-1:0]                count;
    logic                         ans_valid;
    logic [CODE_W-1:0]            ans_code;
    logic [EVENT_W-1:0]           events;
  } state_type;

  state_type state;
  state_type next_state;

  function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
    ptr_inc = (int'(p) == DEPTH - 1) ? '0 : PW'(int'(p) + 1);
  endfunction : ptr_inc

  // pick lowest-numbered pending source; one error queued per cycle
  logic [NUM_SRC-1:0] src_req;
  logic               exp_big;
  logic               push;
  logic [CODE_W-1:0]  push_code;
  logic [EVENT_W-1:0] push_class;

  always_comb begin
    exp_big = exponent_valid && (($signed(exponent_value) > EXP_LIMIT) ||
                                 ($signed(exponent_value) < -EXP_LIMIT)); // R9
    src_req = {memory_use_bad, program_syntax_bad, program_data_bad, // R16
               program_running_op, program_name_bad, // R14 R15
               hardware_missing && eval_done, hardware_fault && eval_done, // R13 R7
               setting_conflict && eval_done, command_disabled && eval_done, // R12 R11 R7
               string_invalid, numeric_malformed, exp_big, // R10 R9
               suffix_out_of_range, trigger_in_message}; // R8
    push      = 1'b0;
    push_code = CODE_NONE;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (src_req[i]) begin
        push      = 1'b1;
        push_code = SRC_CODES[i*16 +: 16];
      end
    end
    if (!push && other_error) begin
      push      = 1'b1;
      push_code = other_code;
    end
  end

  error_class_decode u_class (
    .code       (push_code),
    .valid      (push),
    .class_bits (push_class)
  );

  // any higher-priority source pending, per source
  wire [NUM_SRC-1:0] src_lower;

  assign src_lower[0] = 1'b0;

  for (genvar g = 1; g < NUM_SRC; g++) begin : g_lower
    assign src_lower[g] = src_lower[g-1] | src_req[g-1];
  end

  logic [PW-1:0] newest;

  always_comb begin
    next_state           = state;
    next_state.ans_valid = 1'b0;
    next_state.events    = clear_status ? '0 : push_class; // R5 R6 R17 R18
    newest               = (state.wr_ptr == '0) ? PW'(DEPTH - 1) : PW'(int'(state.wr_ptr) - 1);
    if (clear_status) begin
      next_state.rd_ptr = '0; // R4
      next_state.wr_ptr = '0;
      next_state.count  = '0;
    end else begin
      if (error_query) begin
        next_state.ans_valid = 1'b1;
        if (state.count == '0) begin
          next_state.ans_code = CODE_NONE; // R3
        end else begin
          next_state.ans_code = state.mem[state.rd_ptr]; // R1
          next_state.rd_ptr   = ptr_inc(state.rd_ptr);
          next_state.count    = state.count - CW'(1);
          if (state.count == CW'(1)) begin
            next_state.rd_ptr = '0; // R4
            next_state.wr_ptr = '0;
          end
        end
      end
      if (push) begin
        if (state.count == CW'(DEPTH) && !error_query) begin
          next_state.mem[newest] = CODE_OVERFLOW; // R2
        end else if (state.count == CW'(1) && error_query) begin
          next_state.mem[0]  = push_code;
          next_state.rd_ptr  = '0;
          next_state.wr_ptr  = ptr_inc('0);
          next_state.count   = CW'(1);
        end else begin
          next_state.mem[next_state.wr_ptr] = push_code; // R1
          next_state.wr_ptr = ptr_inc(next_state.wr_ptr);
          next_state.count  = next_state.count + CW'(1);
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign answer_valid = state.ans_valid;
  assign answer_code  = state.ans_code;
  assign event_set    = state.events;
  assign queue_count  = state.count;

  sequence query_on_empty_s;
    error_query && !clear_status && state.count == '0;
  endsequence

  sequence zero_answer_s;
    answer_valid && answer_code == CODE_NONE;
  endsequence

  empty_answers_zero_a: assert property (@(posedge mclk) disable iff (!resetn) // R3
    query_on_empty_s |=> zero_answer_s) else $error("empty queue did not answer zero");

  clear_empties_a: assert property (@(posedge mclk) disable iff (!resetn) // R4
    clear_status |=> queue_count == '0) else $error("clear did not empty queue");

  overflow_code_a: assert property (@(posedge mclk) disable iff (!resetn) // R2
    push && !error_query && !clear_status && state.count == CW'(DEPTH)
      |=> state.mem[$past(newest)] == CODE_OVERFLOW && queue_count == CW'(DEPTH))
    else $error("overflow code not substituted");

  order_kept_a: assert property (@(posedge mclk) disable iff (!resetn) // R1
    error_query && !clear_status && state.count != '0
      |=> answer_code == $past(state.mem[state.rd_ptr])) else $error("answer out of order");

  cmd_class_a: assert property (@(posedge mclk) disable iff (!resetn) // R5
    push && !clear_status && push_code == CODE_EXPONENT |=> event_set[BIT_CMD] && !event_set[BIT_EXEC])
    else $error("command class bit wrong");

  exec_class_a: assert property (@(posedge mclk) disable iff (!resetn) // R6
    push && !clear_status && push_code == CODE_CONFLICT |=> event_set[BIT_EXEC] && !event_set[BIT_CMD])
    else $error("execution class bit wrong");

  device_class_a: assert property (@(posedge mclk) disable iff (!resetn) // R17
    push && !clear_status && (($signed(push_code) >= DEV_LO && $signed(push_code) <= DEV_HI) ||
                              $signed(push_code) >= DEV_POS_LO) |=> event_set[BIT_DEVICE])
    else $error("device bit missing");

  query_class_a: assert property (@(posedge mclk) disable iff (!resetn) // R18
    push && !clear_status && $signed(push_code) <= QRY_HI && $signed(push_code) >= QRY_LO
      |=> event_set[BIT_QUERY])
    else $error("query bit missing");

  exec_after_eval_a: assert property (@(posedge mclk) disable iff (!resetn) // R7
    command_disabled && !eval_done && !(|src_req) && !other_error |-> !push)
    else $error("execution error queued before evaluation");

  exponent_queued_a: assert property (@(posedge mclk) disable iff (!resetn) // R9
    exponent_valid && $signed(exponent_value) == 32001 && !trigger_in_message && !suffix_out_of_range
      |-> push && push_code == CODE_EXPONENT) else $error("exponent error not queued");

  never_exceed_a: assert property (@(posedge mclk) disable iff (!resetn) // R19
    queue_count <= CW'(DEPTH)) else $error("queue count beyond depth");

  // host side and plain push steps
  sequence query_taken_s;
    error_query && !clear_status;
  endsequence

  sequence plain_push_s;
    push && !error_query && !clear_status && state.count < CW'(DEPTH);
  endsequence

  answer_on_query_a: assert property (@(posedge mclk) disable iff (!resetn) // R1
    query_taken_s |=> answer_valid)
    else $error("query not answered");

  no_stray_answer_a: assert property (@(posedge mclk) disable iff (!resetn) // R1
    !error_query || clear_status |=> !answer_valid)
    else $error("answer without query");

  push_counts_a: assert property (@(posedge mclk) disable iff (!resetn) // R1
    plain_push_s |=> queue_count == $past(state.count) + CW'(1))
    else $error("push did not count");

  push_stores_a: assert property (@(posedge mclk) disable iff (!resetn) // R1
    plain_push_s |=> state.mem[$past(state.wr_ptr)] == $past(push_code))
    else $error("push did not store code");

  last_read_empties_a: assert property (@(posedge mclk) disable iff (!resetn) // R4
    query_taken_s ##0 (!push && state.count == CW'(1)) |=> queue_count == '0)
    else $error("last read did not empty queue");

  idle_no_event_a: assert property (@(posedge mclk) disable iff (!resetn) // R5 R6 R17 R18
    !push || clear_status |=> event_set == '0)
    else $error("event bit without queued error");

  // each source but the exponent check alone queues its own code
  trigger_code_a: assert property (@(posedge mclk) disable iff (!resetn) // R8
    src_req[0] && !src_lower[0] |-> push && push_code == CODE_GET)
    else $error("trigger code not queued");

  suffix_code_a: assert property (@(posedge mclk) disable iff (!resetn) // R8
    src_req[1] && !src_lower[1] |-> push && push_code == CODE_SUFFIX)
    else $error("suffix code not queued");

  numeric_code_a: assert property (@(posedge mclk) disable iff (!resetn) // R10
    src_req[3] && !src_lower[3] |-> push && push_code == CODE_NUMERIC)
    else $error("numeric code not queued");

  string_code_a: assert property (@(posedge mclk) disable iff (!resetn) // R10
    src_req[4] && !src_lower[4] |-> push && push_code == CODE_STRING)
    else $error("string code not queued");

  protected_code_a: assert property (@(posedge mclk) disable iff (!resetn) // R11
    src_req[5] && !src_lower[5] |-> push && push_code == CODE_PROTECTED)
    else $error("protected code not queued");

  conflict_code_a: assert property (@(posedge mclk) disable iff (!resetn) // R12
    src_req[6] && !src_lower[6] |-> push && push_code == CODE_CONFLICT)
    else $error("conflict code not queued");

  hw_error_code_a: assert property (@(posedge mclk) disable iff (!resetn) // R13
    src_req[7] && !src_lower[7] |-> push && push_code == CODE_HW_ERROR)
    else $error("hardware error code not queued");

  hw_missing_code_a: assert property (@(posedge mclk) disable iff (!resetn) // R13
    src_req[8] && !src_lower[8] |-> push && push_code == CODE_HW_MISS)
    else $error("hardware missing code not queued");

  prog_name_code_a: assert property (@(posedge mclk) disable iff (!resetn) // R14
    src_req[9] && !src_lower[9] |-> push && push_code == CODE_PROG_NAME)
    else $error("program name code not queued");

  prog_run_code_a: assert property (@(posedge mclk) disable iff (!resetn) // R15
    src_req[10] && !src_lower[10] |-> push && push_code == CODE_PROG_RUN)
    else $error("program running code not queued");

  param_code_a: assert property (@(posedge mclk) disable iff (!resetn) // R16
    src_req[11] && !src_lower[11] |-> push && push_code == CODE_PARAM)
    else $error("parameter code not queued");

  prog_syntax_code_a: assert property (@(posedge mclk) disable iff (!resetn) // R16
    src_req[12] && !src_lower[12] |-> push && push_code == CODE_PROG_SYN)
    else $error("program syntax code not queued");

  mem_use_code_a: assert property (@(posedge mclk) disable iff (!resetn) // R16
    src_req[13] && !src_lower[13] |-> push && push_code == CODE_MEM_USE)
    else $error("memory use code not queued");
endmodule : error_queue_status_reporter

/* File: tb/error_host.sv */
// host side model: issues error queries and clear-status pulses
// assumes the bench calls ask once per cycle at the falling edge
`timescale 1ns/1ps
module error_host (
  output logic error_query,
  output logic clear_status
);
  initial begin
    error_query  = 1'b0;
    clear_status = 1'b0;
  end
  // one request level per cycle, replaced every call
  task automatic ask(input logic q, input logic c);
    error_query  = q;
    clear_status = c;
  endtask : ask
endmodule : error_host

/* File: tb/error_queue_status_reporter_tb_top.sv */
// bench for the error queue: queue model, directed and random traffic
// assumes registered outputs settle before the falling edge
`timescale 1ns/1ps
module error_queue_status_reporter_tb_top;
  import error_queue_pkg::*;
  localparam int DEPTH_TB = 4;
  logic        mclk = 1'b0;
  logic        resetn = 1'b0;
  logic [12:0] src = '0;
  logic        ed = 1'b0, xv = 1'b0, oe = 1'b0;
  logic [31:0] xval = '0;
  logic [15:0] oc = '0;
  logic        error_query, clear_status, answer_valid;
  logic [15:0] answer_code;
  logic [7:0]  event_set;
  logic [2:0]  queue_count;
  int          error_cnt = 0, cmp_count = 0;
  int          mq[$];
  logic [31:0] rs = 32'h9D424B0E;
  int codes[13] = '{-105, -114, -120, -151, -203, -221, -240, -241, -282, -284, -220, -285, -290};
  int others[11] = '{-100, -199, -200, -299, -300, -399, -400, -499, 5, -500, -99};
  int exps[5] = '{32000, 32001, -32001, -32000, 0};
  error_host host_u (.error_query(error_query), .clear_status(clear_status));
  error_queue_status_reporter #(.DEPTH(DEPTH_TB)) dut_u (
    .mclk(mclk), .resetn(resetn), .trigger_in_message(src[0]), .suffix_out_of_range(src[1]),
    .numeric_malformed(src[2]), .exponent_valid(xv), .exponent_value(xval), .string_invalid(src[3]),
    .eval_done(ed), .command_disabled(src[4]), .setting_conflict(src[5]), .hardware_fault(src[6]),
    .hardware_missing(src[7]), .program_name_bad(src[8]), .program_running_op(src[9]),
    .program_data_bad(src[10]), .program_syntax_bad(src[11]), .memory_use_bad(src[12]),
    .other_error(oe), .other_code(oc), .error_query(error_query), .clear_status(clear_status),
    .answer_valid(answer_valid), .answer_code(answer_code), .event_set(event_set),
    .queue_count(queue_count));
  initial begin
    forever #25 mclk = ~mclk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h00000000);
  endfunction : lfsr
  function automatic logic [7:0] cls(input int c);
    cls = 8'h00;
    cls[BIT_CMD]    = (c >= CMD_LO && c <= CMD_HI);
    cls[BIT_EXEC]   = (c >= EXE_LO && c <= EXE_HI);
    cls[BIT_DEVICE] = (c >= DEV_LO && c <= DEV_HI) || c >= DEV_POS_LO;
    cls[BIT_QUERY]  = (c >= QRY_LO && c <= QRY_HI);
  endfunction : cls
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : check
  // one cycle: drive at the falling edge, update model, compare next falling edge
  task automatic cyc(input logic [12:0] s, input logic x, input int xi, input logic o, input int oci,
                     input logic q, input logic c, input logic e);
    int   code;
    int   ans;
    logic ovf;
    src = s; xv = x; xval = xi; oe = o; oc = oci[15:0]; ed = e;
    host_u.ask(q, c);
    code = 0;
    ans = 0;
    for (int i = 12; i >= 0; i--) begin
      if (i == 1 && x && (xi > EXP_LIMIT || xi < -EXP_LIMIT)) code = -123;
      if (s[i] && (e || i < 4 || i > 7)) code = codes[i];
    end
    if (o && code == 0) code = oci;
    if (c) begin
      mq.delete();
      code = 0;
    end else if (q && mq.size() > 0) ans = mq.pop_front();
    ovf = code != 0 && mq.size() == DEPTH_TB;
    if (ovf) mq[mq.size()-1] = -350;
    else if (code != 0) mq.push_back(code);
    @(negedge mclk);
    check(16'(answer_valid), 16'(q && !c));
    if (q && !c) check(answer_code, ans[15:0]);
    check(16'(queue_count), 16'(mq.size()));
    check(16'(event_set), 16'(cls(code)));
  endtask : cyc
  task automatic close_out;
    $display("checks %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : close_out
  initial begin
    repeat (3000) @(posedge mclk);
    error_cnt++;
    close_out;
  end
  initial begin
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    resetn = 1'b1;
    for (int i = 0; i < 13; i++) cyc(13'h0001 << i, 0, 0, 0, 0, i > 2, 0, 1);
    for (int i = 0; i < 11; i++) cyc('0, 0, 0, 1, others[i], 0, 0, 1);
    for (int i = 0; i < 7; i++) cyc('0, 0, 0, 0, 0, 1, 0, 1);
    for (int i = 0; i < 5; i++) cyc('0, 1, exps[i], 0, 0, 0, 0, 1);
    for (int i = 4; i < 8; i++) cyc(13'h0001 << i, 0, 0, 0, 0, 0, 0, 0);
    cyc('0, 0, 0, 0, 0, 0, 1, 1);
    cyc('0, 0, 0, 0, 0, 1, 0, 1);
    for (int n = 0; n < 600; n++) begin
      rs = lfsr(rs);
      cyc(rs[3:0] < 13 ? 13'h0001 << rs[3:0] : '0, rs[3:0] == 13, exps[rs[12:8] % 5],
          rs[3:0] == 14, others[rs[20:16] % 11], rs[4], rs[9:5] == 0, rs[10] | rs[11]);
    end
    cyc('0, 0, 0, 0, 0, 0, 0, 1);
    resetn = 1'b0;
    mq.delete();
    @(negedge mclk);
    check(16'(queue_count), 16'h0000);
    check(16'(answer_valid), 16'h0000);
    resetn = 1'b1;
    cyc('0, 0, 0, 0, 0, 1, 0, 1);
    close_out;
  end
endmodule : error_queue_status_reporter_tb_top
